// file: rtl/gspf_defines.vh
// constants of the serial packet framer and deframer
// assumes a 100 MHz core clock and 32-bit apb register access
`ifndef GSPF_DEFINES_VH
`define GSPF_DEFINES_VH

`define GSPF_ESC            8'h10
`define GSPF_END            8'h03

// register byte addresses
`define GSPF_ADDR_CTRL      8'h00
`define GSPF_ADDR_STATUS    8'h04
`define GSPF_ADDR_TX_CMD    8'h08
`define GSPF_ADDR_RX_DATA   8'h0C
`define GSPF_ADDR_AUTO_PEND 8'h10
`define GSPF_ADDR_RPT_IDS   8'h14

// reset values
`define GSPF_CFG0_RST       8'h02
`define GSPF_CFG1_RST       8'h02

// config, control and status bit positions
`define GSPF_C0_ECEF        0
`define GSPF_C0_LLA         1
`define GSPF_C0_DOUBLE      4
`define GSPF_C0_COMBO       5
`define GSPF_C1_ECEF        0
`define GSPF_C1_ENU         1
`define GSPF_CTRL_AUTO_EN   16
`define GSPF_ST_FERR        2
`define GSPF_ST_TXREF       5

// tx command kinds in bits 9:8
`define GSPF_TXK_DATA       2'h0
`define GSPF_TXK_START      2'h1
`define GSPF_TXK_END        2'h2

// report identifiers
`define GSPF_ID_TIME        8'h41
`define GSPF_ID_POS_XYZ_S   8'h42
`define GSPF_ID_VEL_XYZ     8'h43
`define GSPF_ID_HEALTH      8'h46
`define GSPF_ID_POS_LLA_S   8'h4A
`define GSPF_ID_STATUS      8'h4B
`define GSPF_ID_VEL_ENU     8'h56
`define GSPF_ID_SATSEL      8'h6D
`define GSPF_ID_DGPS        8'h82
`define GSPF_ID_POS_XYZ_D   8'h83
`define GSPF_ID_POS_LLA_D   8'h84
`define GSPF_ID_COMBO       8'h8F
`define GSPF_ID_NONE        8'h00

// report schedule
`define GSPF_CLK_HZ         100000000
`define GSPF_FAST_S         1
`define GSPF_SLOW_S         5

// auto pending bit positions
`define GSPF_AP_POS         0
`define GSPF_AP_VEL         1
`define GSPF_AP_SAT         2
`define GSPF_AP_TIME        3
`define GSPF_AP_HEALTH      4
`define GSPF_AP_STAT        5

`endif

// file: rtl/gspf_fifo.v
// gspf_fifo: synchronous fifo with a registered output stage
// assumes one clock; push and pop follow valid/ready
`timescale 1ns/100ps
module gspf_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             core_clk_in, // core clock
	input  wire             nrst_in,     // async reset, active low
	input  wire             in_valid_in, // write request
	output wire             in_ready_out,// room for a word
	input  wire [WIDTH-1:0] in_data_in,  // write data
	output wire             out_valid_out, // word available
	input  wire             out_ready_in,// reader takes word
	output wire [WIDTH-1:0] out_data_out // read data, registered
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	reg             out_valid_reg;
	reg [WIDTH-1:0] out_data_reg;

	wire push = in_valid_in && in_ready_out;
	wire load = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready_in);

	assign in_ready_out  = (count_reg != DEPTH[AW:0]);
	assign out_valid_out = out_valid_reg;
	assign out_data_out  = out_data_reg;

	always @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end

	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr_reg    <= {AW{1'b0}};
			rd_ptr_reg    <= {AW{1'b0}};
			count_reg     <= {(AW+1){1'b0}};
			out_valid_reg <= 1'b0;
			out_data_reg  <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (load) begin
				rd_ptr_reg    <= rd_ptr_reg + 1'b1;
				out_data_reg  <= mem[rd_ptr_reg];
				out_valid_reg <= 1'b1;
			end else if (out_ready_in) begin
				out_valid_reg <= 1'b0;
			end
			if (push && !load) begin
				count_reg <= count_reg + 1'b1;
			end else if (load && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule

// file: rtl/gspf_top.v
// gspf_top: serial packet framer/deframer with automatic report schedule
// assumes byte streams to and from a uart and an apb master for software
`timescale 1ns/100ps
`include "gspf_defines.vh"
module gspf_top #(
	parameter [31:0] FAST_CYCLES = `GSPF_FAST_S * `GSPF_CLK_HZ,
	parameter [3:0]  SLOW_TICKS  = `GSPF_SLOW_S / `GSPF_FAST_S
) (
	input  wire        core_clk_in,   // core clock
	input  wire        nrst_in,       // async reset, active low
	input  wire        psel_in,       // apb select
	input  wire        penable_in,    // apb enable
	input  wire        pwrite_in,     // apb direction
	input  wire [7:0]  paddr_in,      // apb byte address
	input  wire [31:0] pwdata_in,     // apb write data
	output wire [31:0] prdata_out,    // apb read data
	output wire        pready_out,    // apb ready
	output wire        pslverr_out,   // apb error on unmapped address
	input  wire        rx_valid_in,   // received line byte valid
	input  wire [7:0]  rx_data_in,    // received line byte
	output wire        rx_ready_out,  // deframer accepts byte
	output wire        tx_valid_out,  // line byte to send
	output wire [7:0]  tx_data_out,   // line byte, registered
	input  wire        tx_ready_in,   // uart takes byte
	output wire        auto_tick_out  // one-cycle pulse on each report second
);

	// ==========================================================
	// register bus decode
	wire sel_ctrl = (paddr_in == `GSPF_ADDR_CTRL);
	wire sel_stat = (paddr_in == `GSPF_ADDR_STATUS);
	wire sel_txc  = (paddr_in == `GSPF_ADDR_TX_CMD);
	wire sel_rxd  = (paddr_in == `GSPF_ADDR_RX_DATA);
	wire sel_ap   = (paddr_in == `GSPF_ADDR_AUTO_PEND);
	wire sel_ids  = (paddr_in == `GSPF_ADDR_RPT_IDS);
	wire mapped   = sel_ctrl | sel_stat | sel_txc | sel_rxd | sel_ap | sel_ids;

	reg  [7:0]  tx_seq_cnt_reg;
	reg  [31:0] prdata_reg;
	wire        tx_busy   = (tx_seq_cnt_reg != 8'h00);
	wire        access    = psel_in && penable_in;
	assign pready_out     = !(pwrite_in && sel_txc && tx_busy);
	assign pslverr_out    = access && !mapped;
	wire        wr_go     = access && pwrite_in && pready_out && mapped;
	// pop only a word that the setup cycle saw as valid, so none is lost
	wire        rd_pop    = access && !pwrite_in && sel_rxd && prdata_reg[31];

	// ==========================================================
	// control and status registers
	reg  [7:0]  cfg0_reg;
	reg  [7:0]  cfg1_reg;
	reg         auto_en_reg;
	reg         frame_err_reg;
	reg         tx_refused_reg;
	reg         req_pend_reg;
	reg  [5:0]  auto_pend_reg;

	wire        rx_err_set;
	wire        rx_eop_set;
	wire        tx_refuse_set;
	wire        tx_start_ok;
	wire        tx_is_auto;
	wire [5:0]  auto_set;
	wire        fifo_valid;
	wire [9:0]  fifo_data;

	// position id choice, precision by byte 0 bit 4
	wire [7:0] id_pos_ecef = !cfg0_reg[`GSPF_C0_ECEF] ? `GSPF_ID_NONE :
		cfg0_reg[`GSPF_C0_DOUBLE] ? `GSPF_ID_POS_XYZ_D : `GSPF_ID_POS_XYZ_S;
	wire [7:0] id_pos_lla  = !cfg0_reg[`GSPF_C0_LLA] ? `GSPF_ID_NONE :
		cfg0_reg[`GSPF_C0_DOUBLE] ? `GSPF_ID_POS_LLA_D : `GSPF_ID_POS_LLA_S;
	wire [7:0] id_vel_xyz  = cfg1_reg[`GSPF_C1_ECEF] ? `GSPF_ID_VEL_XYZ : `GSPF_ID_NONE;
	wire [7:0] id_vel_enu  = cfg1_reg[`GSPF_C1_ENU] ? `GSPF_ID_VEL_ENU : `GSPF_ID_NONE;
	wire       combo_en    = cfg0_reg[`GSPF_C0_COMBO];

	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg0_reg       <= `GSPF_CFG0_RST;
			cfg1_reg       <= `GSPF_CFG1_RST;
			auto_en_reg    <= 1'b1;
			frame_err_reg  <= 1'b0;
			tx_refused_reg <= 1'b0;
			req_pend_reg   <= 1'b0;
			auto_pend_reg  <= 6'h00;
		end else begin
			if (wr_go && sel_ctrl) begin
				cfg0_reg    <= pwdata_in[7:0];
				cfg1_reg    <= pwdata_in[15:8];
				auto_en_reg <= pwdata_in[`GSPF_CTRL_AUTO_EN];
			end
			// sticky flags: a set in the clearing cycle wins
			frame_err_reg  <= rx_err_set |
				(frame_err_reg & ~(wr_go & sel_stat & pwdata_in[`GSPF_ST_FERR]));
			tx_refused_reg <= tx_refuse_set |
				(tx_refused_reg & ~(wr_go & sel_stat & pwdata_in[`GSPF_ST_TXREF]));
			auto_pend_reg  <= auto_set |
				(auto_pend_reg & ~({6{wr_go & sel_ap}} & pwdata_in[5:0]));
			// a completed host packet permits one reply of a requested kind
			if (rx_eop_set) begin
				req_pend_reg <= 1'b1;
			end else if (tx_start_ok && !tx_is_auto) begin
				req_pend_reg <= 1'b0;
			end
		end
	end

	// read data captured in setup, stable through the access phase
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prdata_reg <= 32'h00000000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			if (sel_ctrl) begin
				prdata_reg <= {15'h0000, auto_en_reg, cfg1_reg, cfg0_reg};
			end else if (sel_stat) begin
				prdata_reg <= {26'h0000000, tx_refused_reg, combo_en, req_pend_reg,
					frame_err_reg, tx_busy, fifo_valid};
			end else if (sel_rxd) begin
				// identifier arrives flagged as packet start
				prdata_reg <= {fifo_valid, 21'h000000, fifo_data};
			end else if (sel_ap) begin
				prdata_reg <= {26'h0000000, auto_pend_reg};
			end else if (sel_ids) begin
				prdata_reg <= {id_vel_enu, id_vel_xyz, id_pos_lla, id_pos_ecef};
			end else begin
				prdata_reg <= 32'h00000000;
			end
		end
	end
	assign prdata_out = prdata_reg;

	// ==========================================================
	// automatic report schedule
	reg [31:0] fast_cnt_reg;
	reg [3:0]  slow_cnt_reg;
	wire fast_tick = auto_en_reg && (fast_cnt_reg == FAST_CYCLES - 32'h1);
	wire slow_tick = fast_tick && (slow_cnt_reg == SLOW_TICKS - 4'h1);

	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fast_cnt_reg <= 32'h00000000;
			slow_cnt_reg <= 4'h0;
		end else if (!auto_en_reg || fast_tick) begin
			fast_cnt_reg <= 32'h00000000;
			if (fast_tick) begin
				slow_cnt_reg <= slow_tick ? 4'h0 : slow_cnt_reg + 4'h1;
			end
		end else begin
			fast_cnt_reg <= fast_cnt_reg + 32'h1;
		end
	end

	assign auto_tick_out = fast_tick;
	assign auto_set = {slow_tick, slow_tick, slow_tick,
		fast_tick, fast_tick, fast_tick};

	// ==========================================================
	// transmit framer: two-byte shift stage fed by software commands
	reg  [15:0] tx_seq_reg;
	wire [1:0]  tx_kind = pwdata_in[9:8];
	wire [7:0]  tx_byte = pwdata_in[7:0];
	wire        tx_cmd  = wr_go && sel_txc;

	wire tx_id_bad = (tx_byte == `GSPF_ESC) || (tx_byte == `GSPF_END);
	assign tx_is_auto = (tx_byte == `GSPF_ID_TIME) || (tx_byte == `GSPF_ID_POS_XYZ_S) ||
		(tx_byte == `GSPF_ID_VEL_XYZ)  || (tx_byte == `GSPF_ID_HEALTH)    ||
		(tx_byte == `GSPF_ID_POS_LLA_S) || (tx_byte == `GSPF_ID_STATUS)   ||
		(tx_byte == `GSPF_ID_VEL_ENU)  || (tx_byte == `GSPF_ID_SATSEL)    ||
		(tx_byte == `GSPF_ID_DGPS)     || (tx_byte == `GSPF_ID_POS_XYZ_D) ||
		(tx_byte == `GSPF_ID_POS_LLA_D) || (tx_byte == `GSPF_ID_COMBO);
	wire tx_start = tx_cmd && (tx_kind == `GSPF_TXK_START);
	assign tx_start_ok   = tx_start && !tx_id_bad && (tx_is_auto || req_pend_reg);
	assign tx_refuse_set = tx_start && !tx_start_ok;

	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_seq_reg     <= 16'h0000;
			tx_seq_cnt_reg <= 8'h00;
		end else if (tx_cmd && tx_kind == `GSPF_TXK_DATA) begin
			// software supplies field bytes most significant first
			if (tx_byte == `GSPF_ESC) begin
				tx_seq_reg     <= {`GSPF_ESC, `GSPF_ESC};
				tx_seq_cnt_reg <= 8'h02;
			end else begin
				tx_seq_reg     <= {tx_byte, 8'h00};
				tx_seq_cnt_reg <= 8'h01;
			end
		end else if (tx_start_ok) begin
			tx_seq_reg     <= {`GSPF_ESC, tx_byte};
			tx_seq_cnt_reg <= 8'h02;
		end else if (tx_cmd && tx_kind == `GSPF_TXK_END) begin
			tx_seq_reg     <= {`GSPF_ESC, `GSPF_END};
			tx_seq_cnt_reg <= 8'h02;
		end else if (tx_busy && tx_ready_in) begin
			tx_seq_reg     <= {tx_seq_reg[7:0], 8'h00};
			tx_seq_cnt_reg <= tx_seq_cnt_reg - 8'h01;
		end
	end

	assign tx_valid_out = tx_busy;
	assign tx_data_out  = tx_seq_reg[15:8];

	// ==========================================================
	// receive deframer
	localparam [3:0] ST_HUNT = 4'b0001;
	localparam [3:0] ST_HESC = 4'b0010;
	localparam [3:0] ST_BODY = 4'b0100;
	localparam [3:0] ST_BESC = 4'b1000;

	reg  [3:0] rx_state_reg;
	reg  [3:0] rx_state_next;
	reg        emit;
	reg        emit_sop;
	reg        emit_eop;
	reg        err;
	wire       fifo_in_ready;
	wire       rx_take = rx_valid_in && fifo_in_ready;
	wire       is_esc  = (rx_data_in == `GSPF_ESC);
	wire       is_end  = (rx_data_in == `GSPF_END);

	assign rx_ready_out = fifo_in_ready;

	always @* begin
		rx_state_next = rx_state_reg;
		emit          = 1'b0;
		emit_sop      = 1'b0;
		emit_eop      = 1'b0;
		err           = 1'b0;
		case (rx_state_reg)
		ST_HUNT: begin
			if (is_esc) begin
				rx_state_next = ST_HESC;
			end
		end
		ST_HESC: begin
			if (is_esc) begin
				rx_state_next = ST_HESC;
			end else if (is_end) begin
				rx_state_next = ST_HUNT;
			end else begin
				emit          = 1'b1;
				emit_sop      = 1'b1;
				rx_state_next = ST_BODY;
			end
		end
		ST_BODY: begin
			if (is_esc) begin
				rx_state_next = ST_BESC;
			end else begin
				emit = 1'b1;
			end
		end
		ST_BESC: begin
			if (is_esc) begin
				emit          = 1'b1;
				rx_state_next = ST_BODY;
			end else if (is_end) begin
				emit          = 1'b1;
				emit_eop      = 1'b1;
				rx_state_next = ST_HUNT;
			end else begin
				// lone escape before a legal id: error, then take it as a start
				err           = 1'b1;
				emit          = 1'b1;
				emit_sop      = 1'b1;
				rx_state_next = ST_BODY;
			end
		end
		default: begin
			rx_state_next = ST_HUNT;
		end
		endcase
	end

	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_state_reg <= ST_HUNT;
		end else if (rx_take) begin
			rx_state_reg <= rx_state_next;
		end
	end

	assign rx_err_set = rx_take && err;
	assign rx_eop_set = rx_take && emit_eop;

	// ==========================================================
	// receive buffer: {sop, eop, byte}
	gspf_fifo #(
		.WIDTH (10),
		.DEPTH (32),
		.AW    (5)
	) u_rx_fifo (
		.core_clk_in   (core_clk_in),
		.nrst_in       (nrst_in),
		.in_valid_in   (rx_valid_in && emit),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    ({emit_sop, emit_eop, rx_data_in}),
		.out_valid_out (fifo_valid),
		.out_ready_in  (rd_pop),
		.out_data_out  (fifo_data)
	);

endmodule

// file: test/gspf_asserts.sv
// checker for the packet framer: tx framing, apb answers, report tick
// assumes it is bound to gspf_top and sees only its ports
`timescale 1ns/100ps
module gspf_asserts #(
	parameter [31:0] FAST_CYCLES = 200
) (
	input wire        core_clk_in,   // clock
	input wire        nrst_in,       // reset, active low
	input wire        psel_in,       // apb select
	input wire        penable_in,    // apb enable
	input wire        pwrite_in,     // apb direction
	input wire [7:0]  paddr_in,      // apb address
	input wire        pready_out,    // apb ready
	input wire        pslverr_out,   // apb error
	input wire        tx_valid_out,  // line byte valid
	input wire [7:0]  tx_data_out,   // line byte
	input wire        tx_ready_in,   // line byte taken
	input wire        auto_tick_out  // report second
);
	logic [1:0]  nb;
	logic        odd;
	logic [31:0] gap;
	logic        seen;
	wire         take  = tx_valid_out && tx_ready_in;
	wire         close = take && nb[1] && odd && tx_data_out == 8'h03;
	// byte position in frame and escape run parity inside the payload
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			nb   <= 2'h0;
			odd  <= 1'b0;
			gap  <= 32'h0;
			seen <= 1'b0;
		end else begin
			gap  <= auto_tick_out ? 32'h0 : gap + 32'h1;
			seen <= seen | auto_tick_out;
			if (close) begin
				nb  <= 2'h0;
				odd <= 1'b0;
			end else if (take) begin
				nb  <= (nb == 2'h3) ? nb : nb + 2'h1;
				odd <= nb[1] && tx_data_out == 8'h10 && !odd;
			end
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_stall;
		tx_valid_out && !tx_ready_in;
	endsequence
	sequence s_held;
		tx_valid_out && $stable(tx_data_out);
	endsequence
	a_tx_byte_held: assert property (s_stall |=> s_held)
		else $error("tx byte changed while stalled");
	a_tx_frame_open: assert property (take && nb == 2'h0 |-> tx_data_out == 8'h10)
		else $error("frame does not open with escape");
	a_tx_id_legal: assert property (take && nb == 2'h1 |->
		tx_data_out != 8'h10 && tx_data_out != 8'h03)
		else $error("illegal identifier sent");
	a_tx_escape_pair: assert property (take && nb[1] && odd |->
		tx_data_out == 8'h10 || tx_data_out == 8'h03)
		else $error("lone escape in payload");
	a_tx_end_idle: assert property (close |=> !tx_valid_out)
		else $error("tx still busy after trailer");
	a_apb_err_map: assert property (psel_in && penable_in |->
		pslverr_out == (paddr_in > 8'h14 || paddr_in[1:0] != 2'h0))
		else $error("slave error does not match address map");
	a_apb_read_now: assert property (psel_in && penable_in && !pwrite_in |-> pready_out)
		else $error("read access stalled");
	a_tick_period: assert property (auto_tick_out && seen |-> gap == FAST_CYCLES - 1)
		else $error("report tick period wrong");
	a_tick_single: assert property (auto_tick_out |=> !auto_tick_out)
		else $error("report tick longer than one cycle");
endmodule
bind gspf_top gspf_asserts #(.FAST_CYCLES(FAST_CYCLES)) u_chk (
	.core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .tx_valid_out(tx_valid_out),
	.tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in), .auto_tick_out(auto_tick_out)
);

// file: test/gspf_host.sv
// host model on the serial side: sinks tx bytes, sources rx bytes
// assumes the testbench fills send_q and reads got_q
`timescale 1ns/100ps
module gspf_host (
	input  wire        core_clk_in,  // clock
	input  wire        slow_in,      // stall every other cycle
	input  wire        tx_valid_in,  // byte offered by device
	input  wire [7:0]  tx_data_in,   // byte from device
	output logic       tx_ready_out, // host takes byte
	output logic       rx_valid_out, // byte to device
	output logic [7:0] rx_data_out,  // byte to device
	input  wire        rx_ready_in   // device takes byte
);
	logic [7:0] send_q[$];
	logic [7:0] got_q[$];
	initial begin
		tx_ready_out = 1'b0;
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
	end
	always @(posedge core_clk_in) begin
		tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
		if (tx_valid_in && tx_ready_out)
			got_q.push_back(tx_data_in);
		if (rx_valid_out && rx_ready_in)
			void'(send_q.pop_front());
		rx_valid_out <= send_q.size() != 0;
		// idle line shows a changing pattern, the last byte and its inverse in turn
		rx_data_out <= (send_q.size() != 0) ? send_q[0] : ~rx_data_out;
	end
endmodule

// file: test/testbench.sv
// testbench for gspf_top: apb master, host model, scenario tasks
// assumes a short report second of 200 cycles
`timescale 1ns/100ps
module testbench;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        slow = 1'b0;
	logic        full_seen = 1'b0;
	logic        last_err;
	logic [31:0] rd;
	int          err_total = 0;
	int          total_checks = 0;
	wire  [31:0] prdata;
	wire  [7:0]  rx_data, tx_data;
	wire         pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, tick;
	always #5 clk = ~clk;
	always @(posedge clk) if (nrst && rx_ready === 1'b0) full_seen <= 1'b1;
	gspf_top #(.FAST_CYCLES(32'd200)) u_dut (
		.core_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .rx_valid_in(rx_valid),
		.rx_data_in(rx_data), .rx_ready_out(rx_ready), .tx_valid_out(tx_valid),
		.tx_data_out(tx_data), .tx_ready_in(tx_ready), .auto_tick_out(tick));
	gspf_host u_host (
		.core_clk_in(clk), .slow_in(slow), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
		.tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
		.rx_ready_in(rx_ready));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 2000) begin
			n++;
			@(posedge clk);
		end
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 2000) chk(32'h0, 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic pop_chk(input logic [31:0] exp);
		int n;
		n = 0;
		do apb(1'b0, 8'h0C, 32'h0); while (rd[31] !== 1'b1 && n++ < 100);
		chk(rd, exp);
	endtask
	task automatic wait_got(input int n);
		int k;
		k = 0;
		while (u_host.got_q.size() < n && k++ < 500) @(posedge clk);
	endtask
	function automatic logic [31:0] gw(input int i);
		return {u_host.got_q[i], u_host.got_q[i+1], u_host.got_q[i+2], u_host.got_q[i+3]};
	endfunction
	task automatic t_regs;
		rdchk(8'h00, 32'h0001_0202);
		rdchk(8'h14, 32'h5600_4A00);
		rdchk(8'h18, 32'h0);
		chk({31'h0, last_err}, 32'h1);
		wr(8'h00, 32'h0001_0113);
		rdchk(8'h14, 32'h0043_8483);
		wr(8'h00, 32'h0001_0221);
		rdchk(8'h14, 32'h5600_0042);
		rdchk(8'h04, 32'h10);
		wr(8'h00, 32'h0001_0202);
		$display("test regs done");
	endtask
	task automatic t_tx;
		logic [11:0] cmd_list [5] = '{12'h141, 12'h010, 12'h003, 12'h055, 12'h200};
		slow <= 1'b1;
		wr(8'h08, 32'h110);
		rdchk(8'h04, 32'h20);
		wr(8'h04, 32'h20);
		wr(8'h08, 32'h121);
		rdchk(8'h04, 32'h20);
		wr(8'h04, 32'h20);
		chk(u_host.got_q.size(), 32'h0);
		foreach (cmd_list[i])
			wr(8'h08, {20'h0, cmd_list[i]});
		wait_got(8);
		chk(gw(0), 32'h1041_1010);
		chk(gw(4), 32'h0355_1003);
		chk(u_host.got_q.size(), 32'h8);
		u_host.got_q.delete();
		$display("test tx done");
	endtask
	task automatic t_rx;
		u_host.send_q = '{8'h10, 8'h41, 8'h10, 8'h10, 8'h03, 8'h10, 8'h03};
		pop_chk(32'h8000_0241);
		pop_chk(32'h8000_0010);
		pop_chk(32'h8000_0003);
		pop_chk(32'h8000_0103);
		rdchk(8'h04, 32'h08);
		wr(8'h08, 32'h121);
		wr(8'h08, 32'h200);
		wait_got(4);
		chk(gw(0), 32'h1021_1003);
		u_host.got_q.delete();
		// lone escape before a legal id inside a payload restarts the packet
		u_host.send_q = '{8'h10, 8'h41, 8'h55, 8'h10, 8'h42, 8'h10, 8'h03};
		pop_chk(32'h8000_0241);
		pop_chk(32'h8000_0055);
		pop_chk(32'h8000_0242);
		pop_chk(32'h8000_0103);
		rdchk(8'h04, 32'h0C);
		wr(8'h04, 32'h04);
		rdchk(8'h04, 32'h08);
		$display("test rx done");
	endtask
	task automatic t_fill;
		int cnt;
		cnt = 0;
		u_host.send_q = '{8'h10, 8'h41};
		repeat (40) u_host.send_q.push_back(8'h55);
		u_host.send_q.push_back(8'h10);
		u_host.send_q.push_back(8'h03);
		repeat (200) if (!full_seen) @(posedge clk);
		chk({31'h0, full_seen}, 32'h1);
		repeat (120) if (cnt < 42) begin
			apb(1'b0, 8'h0C, 32'h0);
			if (rd[31] === 1'b1) cnt++;
		end
		chk(rd, 32'h8000_0103);
		chk(cnt, 32'd42);
		// empty read: valid low, last word still shown
		rdchk(8'h0C, 32'h0000_0103);
		$display("test fill done");
	endtask
	task automatic t_sched;
		wr(8'h10, 32'h3F);
		repeat (500) if (tick !== 1'b1) @(posedge clk);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd & 32'h7, 32'h7);
		wr(8'h10, 32'h3F);
		repeat (5) begin
			@(posedge clk);
			repeat (500) if (tick !== 1'b1) @(posedge clk);
		end
		rdchk(8'h10, 32'h3F);
		$display("test schedule done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_tx();
		t_rx();
		t_fill();
		t_sched();
		close_out();
	end
	initial begin
		#200000;
		err_total++;
		close_out();
	end
endmodule
